// ---- iopm_chg_det.sv ----
// Level-change detector: per-pin compare with previous sample
`default_nettype none
module iopm_chg_det #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin,
    input  wire logic [W-1:0] sel,
    output logic              change
);
    logic [W-1:0] prev_r;
    logic [W-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev_r[i] <= 1'b0;
                end else if (ce) begin
                    prev_r[i] <= pin[i];
                end
            end
            // First sample after reset may compare against zero; acceptable
            assign hit[i] = sel[i] & (pin[i] ^ prev_r[i]);
        end
    endgenerate

    assign change = |hit;
endmodule : iopm_chg_det
`default_nettype wire

// ---- iopm_pad_model.sv ----
// Pad model: resolves each pin from the block's drive and an outside source
`default_nettype none
module iopm_pad_model (
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] pa_ext,
    output logic      [7:0] pa_in,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pb_ext,
    output logic      [7:0] pb_in,
    input  wire logic [1:0] pc_out,
    input  wire logic [1:0] pc_oe,
    input  wire logic [1:0] pc_ext,
    output logic      [1:0] pc_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Outside source always drives; a floating input would fake level changes
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_ext);
endmodule : iopm_pad_model
`default_nettype wire

// ---- iopm_pkg.sv ----
// Package: register map, reset values and encodings of the I/O port block
`default_nettype none
package iopm_pkg;
    localparam int          NREG      = 27;
    localparam int          AW        = 5;
    localparam int          DW        = 8;
    localparam logic [4:0]  A_DATA_A  = 5'h00;
    localparam logic [4:0]  A_DATA_B  = 5'h01;
    localparam logic [4:0]  A_DATA_C  = 5'h02;
    localparam logic [4:0]  A_DIR_A   = 5'h03;
    localparam logic [4:0]  A_DIR_B   = 5'h04;
    localparam logic [4:0]  A_DIR_C   = 5'h05;
    localparam logic [4:0]  A_PU_A    = 5'h06;
    localparam logic [4:0]  A_PD_AB   = 5'h07;
    localparam logic [4:0]  A_PU_B    = 5'h08;
    localparam logic [4:0]  A_PU_C    = 5'h09;
    localparam logic [4:0]  A_PD_C    = 5'h0a;
    localparam logic [4:0]  A_PWR     = 5'h0b;
    localparam logic [4:0]  A_PWR1    = 5'h0c;
    localparam logic [4:0]  A_OD_B    = 5'h0d;
    localparam logic [4:0]  A_OD_C    = 5'h0e;
    localparam logic [4:0]  A_WAKE_A  = 5'h0f;
    localparam logic [4:0]  A_WAKE_B  = 5'h10;
    localparam logic [4:0]  A_IRQF    = 5'h11;
    localparam logic [4:0]  A_IRQE    = 5'h12;
    localparam logic [4:0]  A_EDGE    = 5'h13;
    localparam logic [4:0]  A_IR_CTRL_REG    = 5'h14;
    localparam logic [4:0]  A_T1CR    = 5'h15;
    localparam logic [4:0]  A_T2CR    = 5'h16;
    localparam logic [4:0]  A_T3CR    = 5'h17;
    localparam logic [4:0]  A_BZ1     = 5'h18;
    localparam logic [4:0]  A_BZ2     = 5'h19;
    localparam logic [4:0]  A_CMP     = 5'h1a;
    // Writable bits per register, index = offset
    localparam logic [7:0]  WMASK [NREG] = '{
        8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff,
        8'h03, 8'h03, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    // Reset values: all pins inputs, everything else off
    localparam logic [7:0]  RSTV [NREG] = '{
        8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h03, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int          B_PA5_PU  = 4;
    localparam int          B_GIE     = 7;
    localparam int          B_LCF     = 1;
    localparam int          B_EXT_IRQ0_SELECT    = 4;
    localparam int          B_EXT_IRQ1_SELECT    = 5;
    localparam int          B_EXT_IRQ2_SELECT    = 6;
    localparam int          B_IR_CARRIER_ENABLE    = 0;
    localparam int          B_TOG     = 5;
    localparam int          B_PWM     = 7;
    localparam int          B_BZ      = 7;
    localparam int          B_COMPARATOR_PIN_ENABLE   = 6;
    typedef enum logic [1:0] {SINK_NORMAL, SINK_LARGE, SINK_CONST} iopm_sink_t;
endpackage : iopm_pkg
`default_nettype wire

// ---- iopm_port.sv ----
// Top of the eighteen-pin I/O port: registers, pad control, alternate functions
// Notes on behaviour
// - Eighteen pins, three ports, each with data register
// - Port A direction bit per pin
// - Port A pull-ups on pins 7,6,4..0
// - Port A pull-downs pin 5, pins 3..0
// - Port B pull-up per pin
// - Shared pull-down high nibble drives port B 3..0
// - Port C pull-up and pull-down per pin
// - Pin A5 pull-up from power control bit 4
// - Port B open-drain select per output pin
// - Port C open-drain select per output pin
// - Wake enables pick pins; change sets flag
// - Level-change request needs both enables set
// - Edge control bits route external interrupt pins
// - External interrupt suppresses level change on pin
// - IR carrier on B1 or A3 by option
// - Pin A5 can be active-low reset input
// - Crystal mode takes A6 input, A7 output
// - RC clock may show instruction clock on A7
// - Pin A4 feeds timer 0 and 1 clocks
// - Pin A2 feeds timers 2 and 3 clock
// - Pin B3 priority: timer3, comparator, buzzer1
// - B6 carries PWM2, B2 carries buzzer2
// - Pin B4: timer1 toggle beats PWM1
// - Two config bits per port choose sink mode
//
// Chosen here: the register offsets and the address-and-strobe port.
`default_nettype none
module iopm_port
    import iopm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic [iopm_pkg::AW-1:0] addr,
    input  wire logic [iopm_pkg::DW-1:0] wdata,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic [iopm_pkg::DW-1:0]    rdata,
    input  wire logic [7:0]            pa_in,
    output logic [7:0]                 pa_out,
    output logic [7:0]                 pa_oe,
    output logic [7:0]                 pa_pu,
    output logic [7:0]                 pa_pd,
    input  wire logic [7:0]            pb_in,
    output logic [7:0]                 pb_out,
    output logic [7:0]                 pb_oe,
    output logic [7:0]                 pb_pu,
    output logic [7:0]                 pb_pd,
    input  wire logic [1:0]            pc_in,
    output logic [1:0]                 pc_out,
    output logic [1:0]                 pc_oe,
    output logic [1:0]                 pc_pu,
    output logic [1:0]                 pc_pd,
    input  wire logic                  cfg_ext_reset_en,
    input  wire logic                  cfg_xtal_en,
    input  wire logic                  cfg_clk_out_en,
    input  wire logic                  cfg_ir_large,
    input  wire logic [2:0]            port_sink_large_cfg,
    input  wire logic [2:0]            port_sink_constant_cfg,
    input  wire logic                  instr_clk_level,
    input  wire logic                  ir_carrier,
    input  wire logic                  timer0_source_select,
    input  wire logic                  timer0_low_clock_select,
    input  wire logic                  timer1_source_select,
    input  wire logic                  timer2_source_select,
    input  wire logic                  timer3_source_select,
    input  wire logic                  timer1_toggle_out,
    input  wire logic                  timer3_toggle_out,
    input  wire logic                  pwm1_out,
    input  wire logic                  pwm2_out,
    input  wire logic                  buzzer1_out,
    input  wire logic                  buzzer2_out,
    input  wire logic                  comparator_out,
    output logic                       ext_reset_n,
    output logic                       ext_clock_in_a,
    output logic                       ext_clock_in_b,
    output logic [2:0]                 ext_irq_pin,
    output logic                       level_change_irq,
    output iopm_pkg::iopm_sink_t       sink_mode_a,
    output iopm_pkg::iopm_sink_t       sink_mode_b,
    output iopm_pkg::iopm_sink_t       sink_mode_c
);
    import iopm_pkg::*;

    logic [7:0] regs_r [NREG];
    logic       lc_change;
    logic [7:0] pa_val;
    logic [7:0] pa_drv;
    logic [7:0] pb_val;
    logic [7:0] pb_drv;
    logic [7:0] pb_alt;
    logic [7:0] xtal_mask;
    logic       ir_on;
    logic       clk_obs;
    logic [7:0] wake_a_eff;
    logic [7:0] rd_nxt;

    // Register file; level-change flag set wins over software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < NREG; r++) begin
                regs_r[r] <= RSTV[r];
            end
        end else if (ce) begin
            for (int r = 0; r < NREG; r++) begin
                if (wr_en && addr == AW'(r)) begin
                    regs_r[r] <= wdata & WMASK[r];
                end
            end
            if (lc_change) begin
                regs_r[A_IRQF][B_LCF] <= 1'b1;
            end
        end
    end

    // Data registers read the pads; direction-agnostic
    always_comb begin
        rd_nxt = 8'h00;
        case (addr)
            A_DATA_A: rd_nxt = pa_in;
            A_DATA_B: rd_nxt = pb_in;
            A_DATA_C: rd_nxt = {6'h00, pc_in};
            default: begin
                if (addr < AW'(NREG)) begin
                    rd_nxt = regs_r[addr];
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd_en ? rd_nxt : 8'h00;
        end
    end

    // External interrupt pin takes precedence over level change
    always_comb begin
        wake_a_eff = regs_r[A_WAKE_A];
        wake_a_eff[4] = wake_a_eff[4] & ~regs_r[A_EDGE][B_EXT_IRQ0_SELECT];
        wake_a_eff[3] = wake_a_eff[3] & ~regs_r[A_EDGE][B_EXT_IRQ1_SELECT];
        wake_a_eff[5] = wake_a_eff[5] & ~regs_r[A_EDGE][B_EXT_IRQ2_SELECT];
    end

    iopm_chg_det #(
        .W      (16)
    ) u_chg (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .pin    ({pb_in, pa_in}),
        .sel    ({regs_r[A_WAKE_B], wake_a_eff}),
        .change (lc_change)
    );

    assign level_change_irq = regs_r[A_IRQF][B_LCF] & regs_r[A_IRQE][B_LCF]
                              & regs_r[A_PWR1][B_GIE];

    assign ext_irq_pin[0] = regs_r[A_EDGE][B_EXT_IRQ0_SELECT] & pa_in[4];
    assign ext_irq_pin[1] = regs_r[A_EDGE][B_EXT_IRQ1_SELECT] & pa_in[3];
    assign ext_irq_pin[2] = regs_r[A_EDGE][B_EXT_IRQ2_SELECT] & pa_in[5];

    // Unselected clock taps held low so timers see no stray edges
    assign ext_clock_in_a = pa_in[4] & ((timer0_source_select & ~timer0_low_clock_select)
                                        | timer1_source_select);
    assign ext_clock_in_b = pa_in[2] & (timer2_source_select
                                        | timer3_source_select);
    assign ext_reset_n = cfg_ext_reset_en ? pa_in[5] : 1'b1;

    assign ir_on     = regs_r[A_IR_CTRL_REG][B_IR_CARRIER_ENABLE];
    assign clk_obs   = cfg_clk_out_en & ~cfg_xtal_en;
    assign xtal_mask = cfg_xtal_en ? 8'hc0 : 8'h00;

    // Port A values and drive; A5 is always open-drain
    always_comb begin
        pa_val = regs_r[A_DATA_A];
        pa_drv = ~regs_r[A_DIR_A];
        if (ir_on && cfg_ir_large) begin
            pa_val[3] = ir_carrier;
            pa_drv[3] = 1'b1;
        end
        if (clk_obs) begin
            pa_val[7] = instr_clk_level;
            pa_drv[7] = 1'b1;
        end
        if (cfg_ext_reset_en) begin
            pa_drv[5] = 1'b0;
        end
        pa_drv = pa_drv & ~xtal_mask;
    end

    assign pa_out = pa_val;
    assign pa_oe  = {pa_drv[7:6], pa_drv[5] & ~pa_val[5], pa_drv[4:0]};
    // Pulls follow real drive, so alternate outputs drop them
    assign pa_pu  = ~pa_drv & ~xtal_mask
                    & {regs_r[A_PU_A][7:6], regs_r[A_PWR][B_PA5_PU],
                       regs_r[A_PU_A][4:0]};
    assign pa_pd  = ~pa_drv
                    & {2'b00, regs_r[A_PU_A][5], 1'b0, regs_r[A_PD_AB][3:0]};

    // Port B alternate outputs with fixed priorities
    always_comb begin
        pb_val = regs_r[A_DATA_B];
        pb_alt = 8'h00;
        if (ir_on && !cfg_ir_large) begin
            pb_val[1] = ir_carrier;
            pb_alt[1] = 1'b1;
        end
        if (regs_r[A_BZ2][B_BZ]) begin
            pb_val[2] = buzzer2_out;
            pb_alt[2] = 1'b1;
        end
        if (regs_r[A_T3CR][B_TOG]) begin
            pb_val[3] = timer3_toggle_out;
            pb_alt[3] = 1'b1;
        end else if (regs_r[A_CMP][B_COMPARATOR_PIN_ENABLE]) begin
            pb_val[3] = comparator_out;
            pb_alt[3] = 1'b1;
        end else if (regs_r[A_BZ1][B_BZ]) begin
            pb_val[3] = buzzer1_out;
            pb_alt[3] = 1'b1;
        end
        if (regs_r[A_T1CR][B_TOG]) begin
            pb_val[4] = timer1_toggle_out;
            pb_alt[4] = 1'b1;
        end else if (regs_r[A_T1CR][B_PWM]) begin
            pb_val[4] = pwm1_out;
            pb_alt[4] = 1'b1;
        end
        if (regs_r[A_T2CR][B_PWM]) begin
            pb_val[6] = pwm2_out;
            pb_alt[6] = 1'b1;
        end
        pb_drv = ~regs_r[A_DIR_B] | pb_alt;
    end

    // Open-drain: a driven high becomes release
    assign pb_out = pb_val;
    assign pb_oe  = pb_drv & ~(regs_r[A_OD_B] & pb_val);
    assign pb_pu  = regs_r[A_DIR_B] & ~pb_alt & regs_r[A_PU_B];
    assign pb_pd  = regs_r[A_DIR_B] & ~pb_alt
                    & {4'h0, regs_r[A_PD_AB][7:4]};

    assign pc_out = regs_r[A_DATA_C][1:0];
    assign pc_oe  = ~regs_r[A_DIR_C][1:0]
                    & ~(regs_r[A_OD_C][1:0] & pc_out);
    assign pc_pu  = regs_r[A_DIR_C][1:0] & regs_r[A_PU_C][1:0];
    assign pc_pd  = regs_r[A_DIR_C][1:0] & regs_r[A_PD_C][1:0];

    // Sink mode per port; large-off with constant-on is treated as normal
    function automatic iopm_sink_t sink_dec(input logic lg, input logic cs);
        sink_dec = !lg ? SINK_NORMAL : (cs ? SINK_CONST : SINK_LARGE);
    endfunction : sink_dec

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_mode_a <= SINK_NORMAL;
            sink_mode_b <= SINK_NORMAL;
            sink_mode_c <= SINK_NORMAL;
        end else if (ce) begin
            sink_mode_a <= sink_dec(port_sink_large_cfg[0], port_sink_constant_cfg[0]);
            sink_mode_b <= sink_dec(port_sink_large_cfg[1], port_sink_constant_cfg[1]);
            sink_mode_c <= sink_dec(port_sink_large_cfg[2], port_sink_constant_cfg[2]);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_chg;
        ce && lc_change;
    endsequence
    sequence s_no_clear;
        !(ce && wr_en && addr == A_IRQF);
    endsequence

    flag_sets_a: assert property (s_chg |=> regs_r[A_IRQF][B_LCF])
        else $error("level change did not set flag");

    flag_sticks_a: assert property ((regs_r[A_IRQF][B_LCF] and s_no_clear)
                                    |=> regs_r[A_IRQF][B_LCF])
        else $error("level change flag dropped without write");

    flag_clear_a: assert property (ce && wr_en && addr == A_IRQF && !wdata[B_LCF]
                                   && !lc_change |=> !regs_r[A_IRQF][B_LCF])
        else $error("flag not cleared");

    irq_gate_a: assert property (level_change_irq |-> regs_r[A_PWR1][B_GIE]
                                 && regs_r[A_IRQE][B_LCF])
        else $error("request without both enables");

    ext_prio_a: assert property (ce && regs_r[A_EDGE][B_EXT_IRQ1_SELECT] && pa_in[3] != $past(pa_in[3])
                                 && regs_r[A_WAKE_B] == 8'h00
                                 && (regs_r[A_WAKE_A] & 8'hf7) == 8'h00
                                 |-> !lc_change)
        else $error("level change seen on interrupt pin");

    pb3_prio_a: assert property (regs_r[A_T3CR][B_TOG] |-> pb_out[3] == timer3_toggle_out
                                 && pb_drv[3])
        else $error("timer3 toggle lost priority on B3");

    pb4_prio_a: assert property (regs_r[A_T1CR][B_TOG] && regs_r[A_T1CR][B_PWM]
                                 |-> pb_out[4] == timer1_toggle_out)
        else $error("PWM1 beat timer1 toggle on B4");

    od_b_a: assert property (regs_r[A_OD_B][0] && pb_out[0] |-> !pb_oe[0])
        else $error("open-drain pin drove high");

    pc_od_a: assert property (regs_r[A_OD_C][0] && pc_out[0]
                              |-> !pc_oe[0])
        else $error("C open-drain drove");

    read_lat_a: assert property (ce && rd_en && addr == A_DIR_A ##1 ce
                                 |-> rdata == $past(regs_r[A_DIR_A]))
        else $error("direction readback wrong");

    rd_idle_a: assert property (ce && !rd_en |=> rdata == 8'h00)
        else $error("read data stuck");

    xtal_a: assert property (cfg_xtal_en |-> pa_oe[7:6] == 2'b00
                             && pa_pu[7:6] == 2'b00)
        else $error("crystal pins still driven");

    ir_pads_a: assert property (ir_on |-> (cfg_ir_large ? pa_out[3] : pb_out[1])
                                == ir_carrier)
        else $error("carrier on wrong pad");

    rst_pin_a: assert property (cfg_ext_reset_en |-> !pa_oe[5]
                                && ext_reset_n == pa_in[5])
        else $error("reset pin misrouted");

    clk_obs_a: assert property (clk_obs |-> pa_oe[7]
                                && pa_out[7] == instr_clk_level)
        else $error("no clock on A7");

    sink_lag_a: assert property (ce && port_sink_large_cfg[0] && port_sink_constant_cfg[0]
                                 |=> sink_mode_a == SINK_CONST)
        else $error("sink mode wrong");
endmodule : iopm_port
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the eighteen-pin I/O port block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import iopm_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0, rdata;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pu, pa_pd, pb_in, pb_out, pb_oe, pb_pu, pb_pd;
    logic [7:0] ea = '0, eb = '0;
    logic [1:0] pc_in, pc_out, pc_oe, pc_pu, pc_pd, ec = '0;
    logic cfg_ext_reset_en = '0, cfg_xtal_en = '0, cfg_clk_out_en = '0, cfg_ir_large = '0;
    logic [2:0] port_sink_large_cfg = '0, port_sink_constant_cfg = '0, ext_irq_pin;
    logic instr_clk_level = '0, ir_carrier = '0, timer0_source_select = '0;
    logic timer0_low_clock_select = '0, timer1_source_select = '0, timer2_source_select = '0;
    logic timer3_source_select = '0, timer1_toggle_out = '0, timer3_toggle_out = '0;
    logic pwm1_out = '0, pwm2_out = '0, buzzer1_out = '0, buzzer2_out = '0, comparator_out = '0;
    logic ext_reset_n, ext_clock_in_a, ext_clock_in_b, level_change_irq;
    iopm_sink_t sink_mode_a, sink_mode_b, sink_mode_c;
    int bad_count = 0, n_checks = 0, cyc = 0;

    iopm_port i_iopm_port (
        .clk, .rst_n, .ce, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .pa_in, .pa_out, .pa_oe, .pa_pu, .pa_pd, .pb_in, .pb_out, .pb_oe, .pb_pu, .pb_pd,
        .pc_in, .pc_out, .pc_oe, .pc_pu, .pc_pd, .cfg_ext_reset_en, .cfg_xtal_en,
        .cfg_clk_out_en, .cfg_ir_large, .port_sink_large_cfg, .port_sink_constant_cfg,
        .instr_clk_level, .ir_carrier, .timer0_source_select, .timer0_low_clock_select,
        .timer1_source_select, .timer2_source_select, .timer3_source_select,
        .timer1_toggle_out, .timer3_toggle_out, .pwm1_out, .pwm2_out, .buzzer1_out,
        .buzzer2_out, .comparator_out, .ext_reset_n, .ext_clock_in_a, .ext_clock_in_b,
        .ext_irq_pin, .level_change_irq, .sink_mode_a, .sink_mode_b, .sink_mode_c
    );
    iopm_pad_model i_iopm_pad_model (
        .pa_out, .pa_oe, .pa_ext(ea), .pa_in, .pb_out, .pb_oe, .pb_ext(eb), .pb_in,
        .pc_out, .pc_oe, .pc_ext(ec), .pc_in
    );

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Sample mid-cycle so that the edge's updates have landed
    task automatic st(input int n);
        repeat (n) @(negedge clk);
    endtask : st
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask : wr
    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        st(1);
        chk($sformatf("reg %h", a), rdata, exp);
    endtask : rdc
    task automatic pads(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        ea <= a;
        eb <= b;
        st(3);
    endtask : pads

    task automatic t_reset();
        rdc(A_DIR_A, 8'hff);
        rdc(A_DIR_C, 8'h03);
        rdc(5'h1b, 8'h00);
        chk("pa_oe", pa_oe, 8'h00);
        @(posedge clk);
        ec <= 2'h2;
        pads(8'h3c, 8'h81);
        rdc(A_DATA_A, 8'h3c);
        rdc(A_DATA_B, 8'h81);
        rdc(A_DATA_C, 8'h02);
    endtask : t_reset
    task automatic t_out();
        wr(A_DATA_A, 8'ha5);
        wr(A_DIR_A, 8'h00);
        wr(A_DATA_B, 8'h0f);
        wr(A_DIR_B, 8'h00);
        wr(A_DATA_C, 8'h01);
        wr(A_DIR_C, 8'h00);
        st(1);
        // Pin A5 is open-drain by nature, so it is left out here
        chk("pa_oe", pa_oe & 8'hdf, 8'hdf);
        chk("pa_out", pa_out & 8'hdf, 8'h85);
        chk("pb_oe", pb_oe, 8'hff);
        chk("pc_out", {6'h0, pc_out}, 8'h01);
        wr(A_OD_B, 8'hff);
        wr(A_OD_C, 8'h03);
        st(1);
        chk("pb_oe", pb_oe, 8'hf0);
        chk("pb_high", pb_oe & pb_out, 8'h00);
        chk("pc_oe", {6'h0, pc_oe}, 8'h02);
        wr(A_OD_B, 8'h00);
        wr(A_OD_C, 8'h00);
        wr(A_DIR_A, 8'hff);
        wr(A_DIR_B, 8'hff);
        wr(A_DIR_C, 8'h03);
    endtask : t_out
    task automatic t_pull(input logic [7:0] ua, d, ub, input logic [1:0] uc, dc,
                          input logic [7:0] w);
        wr(A_PU_A, ua);
        wr(A_PD_AB, d);
        wr(A_PU_B, ub);
        wr(A_PU_C, {6'h0, uc});
        wr(A_PD_C, {6'h0, dc});
        wr(A_PWR, w);
        st(1);
        chk("pa_pu", pa_pu, (ua & 8'hdf) | {2'h0, w[4], 5'h00});
        chk("pa_pd", pa_pd, {2'h0, ua[5], 1'h0, d[3:0]});
        chk("pb_pu", pb_pu, ub);
        chk("pb_pd", pb_pd, {4'h0, d[7:4]});
        chk("pc_pull", {4'h0, pc_pu, pc_pd}, {4'h0, uc, dc});
    endtask : t_pull
    task automatic t_ce();
        @(posedge clk);
        ce <= 1'h0;
        wr(A_PD_C, 8'h00);
        @(posedge clk);
        ce <= 1'h1;
        rdc(A_PD_C, 8'h03);
        wr(A_PD_C, 8'hfd);
        rdc(A_PD_C, 8'h01);
    endtask : t_ce
    task automatic t_irq();
        pads(8'h38, 8'h81);
        wr(A_EDGE, 8'h70);
        st(1);
        chk("ext_irq", {5'h0, ext_irq_pin}, 8'h07);
        wr(A_EDGE, 8'h10);
        st(1);
        chk("ext_irq", {5'h0, ext_irq_pin}, 8'h01);
        wr(A_EDGE, 8'h20);
        wr(A_WAKE_A, 8'h08);
        wr(A_IRQF, 8'h00);
        pads(8'h30, 8'h81);
        rdc(A_IRQF, 8'h00);
        pads(8'h31, 8'h81);
        rdc(A_IRQF, 8'h00);
        wr(A_EDGE, 8'h00);
        pads(8'h39, 8'h81);
        rdc(A_IRQF, 8'h02);
        chk("lc_irq", {7'h0, level_change_irq}, 8'h00);
        wr(A_IRQE, 8'h02);
        st(1);
        chk("lc_irq", {7'h0, level_change_irq}, 8'h00);
        wr(A_PWR1, 8'h80);
        st(20);
        chk("lc_irq", {7'h0, level_change_irq}, 8'h01);
        rdc(A_IRQF, 8'h02);
        wr(A_IRQF, 8'h00);
        st(1);
        chk("lc_irq", {7'h0, level_change_irq}, 8'h00);
        wr(A_WAKE_B, 8'h80);
        pads(8'h39, 8'h01);
        rdc(A_IRQF, 8'h02);
        wr(A_IRQF, 8'h00);
        wr(A_PWR1, 8'h00);
    endtask : t_irq
    task automatic t_alt();
        wr(A_IR_CTRL_REG, 8'h01);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            ir_carrier <= v[0];
            cfg_ir_large <= 1'h0;
            ea <= {2'h0, v[0], v[0], 1'h0, v[0], 2'h0};
            cfg_ext_reset_en <= 1'h1;
            timer0_source_select <= 1'h1;
            timer2_source_select <= 1'h1;
            st(1);
            chk("b1", {6'h0, pb_oe[1], pb_out[1]}, {7'h1, v[0]});
            chk("rst_in", {7'h0, ext_reset_n}, {7'h0, v[0]});
            chk("clk_ab", {6'h0, ext_clock_in_a, ext_clock_in_b}, {6'h0, v[0], v[0]});
            @(posedge clk);
            cfg_ir_large <= 1'h1;
            cfg_ext_reset_en <= 1'h0;
            {timer0_source_select, timer1_source_select} <= 2'h1;
            {timer2_source_select, timer3_source_select} <= 2'h1;
            st(1);
            chk("a3", {6'h0, pa_oe[3], pa_out[3]}, {7'h1, v[0]});
            chk("rst_in", {7'h0, ext_reset_n}, 8'h01);
            chk("clk_ab", {6'h0, ext_clock_in_a, ext_clock_in_b}, {6'h0, v[0], v[0]});
        end
        @(posedge clk);
        {timer0_source_select, timer0_low_clock_select, timer1_source_select} <= 3'h6;
        st(1);
        chk("clk_a_lo", {7'h0, ext_clock_in_a}, 8'h00);
        wr(A_IR_CTRL_REG, 8'h00);
        st(1);
        chk("ir_off", {6'h0, pa_oe[3], pb_oe[1]}, 8'h00);
    endtask : t_alt
    task automatic t_osc();
        wr(A_DIR_A, 8'h00);
        @(posedge clk);
        cfg_xtal_en <= 1'h1;
        cfg_clk_out_en <= 1'h1;
        st(1);
        chk("a6_oe", {7'h0, pa_oe[6]}, 8'h00);
        wr(A_DIR_A, 8'hff);
        st(1);
        chk("a76_pu", {6'h0, pa_pu[7:6]}, 8'h00);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            cfg_xtal_en <= 1'h0;
            instr_clk_level <= v[0];
            st(1);
            chk("a7", {6'h0, pa_oe[7], pa_out[7]}, {7'h1, v[0]});
        end
        @(posedge clk);
        cfg_clk_out_en <= 1'h0;
    endtask : t_osc
    task automatic t_mux();
        for (int i = 0; i < 8; i++) begin
            wr(A_T3CR, {2'h0, i[2], 5'h00});
            wr(A_CMP, {1'h0, i[1], 6'h00});
            wr(A_BZ1, {i[0], 7'h00});
            wr(A_T1CR, {i[1], 1'h0, i[0], 5'h00});
            wr(A_T2CR, {i[2], 7'h00});
            wr(A_BZ2, {i[0], 7'h00});
            for (int v = 0; v < 8; v++) begin
                logic [7:0] e, x;
                @(posedge clk);
                {timer3_toggle_out, comparator_out, buzzer1_out} <= v[2:0];
                {pwm2_out, pwm1_out, timer1_toggle_out} <= v[2:0];
                buzzer2_out <= v[1];
                st(1);
                e = {1'h0, i[2], 1'h0, |i[1:0], i != 0, i[0], 2'h0};
                x = {1'h0, v[2], 1'h0, i[0] ? v[0] : v[1],
                     i[2] ? v[2] : i[1] ? v[1] : v[0], v[1], 2'h0};
                chk("pb_oe", pb_oe & 8'h5c, e);
                chk("pb_out", pb_out & e, x & e);
            end
        end
    endtask : t_mux
    task automatic t_sink();
        iopm_sink_t e;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            port_sink_large_cfg <= {3{k[0]}};
            port_sink_constant_cfg <= {3{k[1]}};
            st(2);
            e = (k == 1) ? SINK_LARGE : (k == 3) ? SINK_CONST : SINK_NORMAL;
            chk("sink", {2'h0, sink_mode_a, sink_mode_b, sink_mode_c}, {2'h0, e, e, e});
        end
    endtask : t_sink

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_out();
        t_pull(8'h5a, 8'ha5, 8'h3c, 2'h1, 2'h2, 8'h00);
        t_pull(8'hff, 8'hff, 8'hff, 2'h3, 2'h3, 8'h10);
        t_ce();
        t_irq();
        t_alt();
        t_osc();
        t_mux();
        t_sink();
        final_report();
    end
endmodule : testbench
`default_nettype wire
